//--- rtl/epr_top.sv
/*
 * Exception priority resolver with an AXI4-Lite register slave.
 * Assumes the exception sequencer pulses svc_take when it fetches the
 * presented vector, and that peripheral flags come from the same clock.
 */
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "epr_defs.svh"

////////////////////////////////////////////////////////////////////////////////

// Operation
// R1: Each exception has its own 16-bit vector inside the top 128 bytes of memory.
// R2: The six top vectors belong to resets and non-maskable sources, the rest to maskable ones.
// R3: Non-maskable order is reset, clock monitor, watchdog, trap, software trap, then the pin.
// R4: The non-maskable pin counts only while the pin mask bit is 0.
// R5: Maskable requests are seen only while the global mask bit is clear.
// R6: The global mask bit resets to 1 and software may change it at any time.
// R7: Maskable sources keep a default order and promotion lifts one without reordering others.
// R8: A promoted source is still blocked by the global mask and its own enable.
// R9: A source always uses its own fixed vector whatever the priority setting.
// R10: The priority select is written only while the global mask bit is set.
// R11: The select is a vector low byte, and an unmatched value puts the pin request on top.
// R12: An edge-mode pin request latch clears when that request is serviced.
// R13: Servicing with nothing pending takes the trap vector.
// R14: The vector of the winning request and a pending flag are shown every cycle.
module epr_top #(
	parameter int N_MASK = `EPR_N_MASK
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              ext_reset_n,
	input  wire logic              clock_monitor_fail,
	input  wire logic              watchdog_reset,
	input  wire logic              illegal_opcode_trap,
	input  wire logic              software_trap_instruction,
	input  wire logic              nonmaskable_pin_request_n,
	input  wire logic              irq_pin_n,
	input  wire logic [N_MASK-2:0] periph_flag,
	input  wire logic [N_MASK-2:0] periph_enable,
	input  wire logic              svc_take,
	output epr_pkg::epr_vec_t      vector_addr,
	output logic                   vector_valid,
	output logic                   global_mask,
	output logic                   pin_mask
);
	import epr_pkg::*;

	////////////////////////////////////////////////////////////////////////////

	// Pins from outside the clock domain are synchronised first.
	logic [2:0] pins_s;

	epr_sync #(
		.W       (3),
		.RST_VAL (3'h7)
	) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({ext_reset_n, nonmaskable_pin_request_n, irq_pin_n}),
		.q     (pins_s)
	);

	logic rst_pin_req, xpin_req, irq_low;
	assign rst_pin_req = ~pins_s[2];
	assign xpin_req    = ~pins_s[1];
	assign irq_low     = ~pins_s[0];

	////////////////////////////////////////////////////////////////////////////

	// Shared address decoder for both bus directions.
	function automatic epr_sel_t decode(input logic [7:0] addr);
		case ({addr[7:2], 2'b00})
			`EPR_OFF_CCR:  decode = SEL_CCR;
			`EPR_OFF_PRIO: decode = SEL_PRIO;
			`EPR_OFF_IRQC: decode = SEL_IRQC;
			`EPR_OFF_STAT: decode = SEL_STAT;
			default:       decode = SEL_NONE;
		endcase
	endfunction : decode

	logic       aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [7:0] w_byte_q, w_byte_d;
	logic       w_lane_q, w_lane_d;
	logic       bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic       wr_fire;
	epr_sel_t   wr_sel;

	assign s_axi_awready = ~aw_got_q & ~bvalid_q;
	assign s_axi_wready  = ~w_got_q & ~bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign wr_fire       = aw_got_q & w_got_q & ~bvalid_q;
	assign wr_sel        = decode(aw_addr_q);

	// Control state; declared here because the write path checks the mask.
	logic      i_q, i_d, x_q, x_d;
	epr_byte_t prio_q, prio_d;
	logic      irq_en_q, irq_en_d, irq_edge_q, irq_edge_d;
	logic      latch_q, latch_d, irq_prev_q, irq_prev_d;
	epr_vec_t  vec_q, vec_d;
	logic      valid_q, valid_d;

	// Address and data are caught independently so either may come first.
	always_comb begin
		aw_got_d  = aw_got_q;
		aw_addr_d = aw_addr_q;
		w_got_d   = w_got_q;
		w_byte_d  = w_byte_q;
		w_lane_d  = w_lane_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_d  = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_d  = 1'b1;
			w_byte_d = s_axi_wdata[7:0];
			w_lane_d = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = `EPR_RESP_OKAY;
			// A refused select write is reported so software sees the mistake.
			if (wr_sel == SEL_NONE || (wr_sel == SEL_PRIO && !i_q))
				bresp_d = `EPR_RESP_SLVERR; // [R10]
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_got_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_got_q   <= 1'b0;
			w_byte_q  <= 8'h00;
			w_lane_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `EPR_RESP_OKAY;
		end else begin
			aw_got_q  <= aw_got_d;
			aw_addr_q <= aw_addr_d;
			w_got_q   <= w_got_d;
			w_byte_q  <= w_byte_d;
			w_lane_q  <= w_lane_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	// Read path answers one cycle after the address is taken.
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;

	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d  = 32'h0000_0000;
			rresp_d  = `EPR_RESP_OKAY;
			case (decode(s_axi_araddr))
				SEL_CCR: begin
					rdata_d[`EPR_CCR_I_BIT] = i_q;
					rdata_d[`EPR_CCR_X_BIT] = x_q;
				end
				SEL_PRIO: rdata_d[7:0] = prio_q;
				SEL_IRQC: begin
					rdata_d[`EPR_IRQC_EDGE_BIT] = irq_edge_q;
					rdata_d[`EPR_IRQC_EN_BIT]   = irq_en_q;
				end
				SEL_STAT: begin
					rdata_d[`EPR_STAT_VALID_BIT]              = valid_q;
					rdata_d[`EPR_STAT_LATCH_BIT]              = latch_q;
					rdata_d[`EPR_STAT_I_BIT]                  = i_q;
					rdata_d[`EPR_STAT_VEC_LSB +: 16]          = vec_q;
				end
				default: rresp_d = `EPR_RESP_SLVERR;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `EPR_RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	// Maskable requests, gated by the global mask before ranking.
	epr_rank_if #(.N_SRC(N_MASK)) rk ();

	epr_rank #(
		.N_SRC (N_MASK)
	) u_rank (
		.rk (rk)
	);

	logic irq_req, taken_irq, taken_top, irq_fall;
	logic byte_wr;

	assign irq_fall = irq_prev_q & irq_low;
	assign irq_req  = irq_en_q & (irq_edge_q ? latch_q : irq_low);
	assign rk.pend  = i_q ? '0 : {periph_flag & periph_enable, irq_req}; // [R5] [R8]
	assign rk.prio_sel = prio_q;
	assign taken_irq   = svc_take && vec_q == {`EPR_VEC_PAGE, `EPR_VEC_IRQ};
	// The external reset and the non-maskable pin leave the pin mask set on entry.
	assign taken_top   = svc_take && (vec_q[7:0] == `EPR_VEC_XPIN
		|| vec_q[7:0] == `EPR_VEC_RESET);
	assign byte_wr     = wr_fire & w_lane_q;

	// Control registers; hardware sets win over a software clear.
	always_comb begin
		i_d        = i_q;
		x_d        = x_q;
		prio_d     = prio_q;
		irq_en_d   = irq_en_q;
		irq_edge_d = irq_edge_q;
		irq_prev_d = ~irq_low;
		if (byte_wr && wr_sel == SEL_CCR) begin
			i_d = w_byte_q[`EPR_CCR_I_BIT]; // [R6]
			x_d = x_q & w_byte_q[`EPR_CCR_X_BIT];
		end
		if (byte_wr && wr_sel == SEL_PRIO && i_q)
			prio_d = w_byte_q; // [R10]
		if (byte_wr && wr_sel == SEL_IRQC) begin
			irq_edge_d = w_byte_q[`EPR_IRQC_EDGE_BIT];
			irq_en_d   = w_byte_q[`EPR_IRQC_EN_BIT];
		end
		if (svc_take)
			i_d = 1'b1;
		if (taken_top)
			x_d = 1'b1;
		// A new edge in the servicing cycle is kept.
		latch_d = irq_fall | (latch_q & ~taken_irq); // [R12]
	end

	// Non-maskable chain, then the ranked maskable winner, else the trap.
	always_comb begin
		valid_d = 1'b1; // [R14]
		if (rst_pin_req)
			vec_d = {`EPR_VEC_PAGE, `EPR_VEC_RESET}; // [R3] [R2]
		else if (clock_monitor_fail)
			vec_d = {`EPR_VEC_PAGE, `EPR_VEC_CLKMON}; // [R3]
		else if (watchdog_reset)
			vec_d = {`EPR_VEC_PAGE, `EPR_VEC_WDOG}; // [R3]
		else if (illegal_opcode_trap)
			vec_d = {`EPR_VEC_PAGE, `EPR_VEC_TRAP}; // [R3]
		else if (software_trap_instruction)
			vec_d = {`EPR_VEC_PAGE, `EPR_VEC_SWI}; // [R3]
		else if (xpin_req && !x_q)
			vec_d = {`EPR_VEC_PAGE, `EPR_VEC_XPIN}; // [R4]
		else if (rk.win_valid)
			vec_d = {`EPR_VEC_PAGE, rk.win_low}; // [R1] [R9]
		else begin
			valid_d = 1'b0;
			vec_d   = {`EPR_VEC_PAGE, `EPR_VEC_TRAP}; // [R13]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			i_q        <= `EPR_RST_I; // [R6]
			x_q        <= `EPR_RST_X;
			prio_q     <= `EPR_RST_PRIO;
			irq_en_q   <= `EPR_RST_IRQ_EN;
			irq_edge_q <= `EPR_RST_IRQ_EDGE;
			latch_q    <= 1'b0;
			irq_prev_q <= 1'b1;
			vec_q      <= {`EPR_VEC_PAGE, `EPR_VEC_TRAP};
			valid_q    <= 1'b0;
		end else begin
			i_q        <= i_d;
			x_q        <= x_d;
			prio_q     <= prio_d;
			irq_en_q   <= irq_en_d;
			irq_edge_q <= irq_edge_d;
			latch_q    <= latch_d;
			irq_prev_q <= irq_prev_d;
			vec_q      <= vec_d;
			valid_q    <= valid_d;
		end
	end

	assign vector_addr  = vec_q;
	assign vector_valid = valid_q;
	assign global_mask  = i_q;
	assign pin_mask     = x_q;
endmodule : epr_top

//--- rtl/epr_defs.svh
/*
 * Constants of the exception priority resolver: register offsets, field
 * positions, reset values and vector locations.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef EPR_DEFS_SVH
`define EPR_DEFS_SVH

// Register byte offsets on the register bus.
`define EPR_OFF_CCR        8'h00
`define EPR_OFF_PRIO       8'h04
`define EPR_OFF_IRQC       8'h08
`define EPR_OFF_STAT       8'h0C

// Field positions.
`define EPR_CCR_I_BIT      4
`define EPR_CCR_X_BIT      6
`define EPR_IRQC_EDGE_BIT  7
`define EPR_IRQC_EN_BIT    6
`define EPR_STAT_VALID_BIT 0
`define EPR_STAT_LATCH_BIT 1
`define EPR_STAT_I_BIT     2
`define EPR_STAT_VEC_LSB   16

// Reset values.
`define EPR_RST_I          1'b1
`define EPR_RST_X          1'b1
`define EPR_RST_PRIO       8'hF2
`define EPR_RST_IRQ_EN     1'b1
`define EPR_RST_IRQ_EDGE   1'b0

// Vector page and the fixed low bytes of the non-maskable vectors.
`define EPR_VEC_PAGE       8'hFF
`define EPR_VEC_RESET      8'hFE
`define EPR_VEC_CLKMON     8'hFC
`define EPR_VEC_WDOG       8'hFA
`define EPR_VEC_TRAP       8'hF8
`define EPR_VEC_SWI        8'hF6
`define EPR_VEC_XPIN       8'hF4

// Maskable vectors: three runs that step down by two bytes.
`define EPR_N_MASK         19
`define EPR_VEC_STEP       2
`define EPR_VEC_IRQ        8'hF2
`define EPR_GRP1_LEN       15
`define EPR_VEC_ATD        8'hD2
`define EPR_GRP2_END       17
`define EPR_VEC_MDC        8'hCC

// AXI responses.
`define EPR_RESP_OKAY      2'b00
`define EPR_RESP_SLVERR    2'b10

`endif

//--- rtl/epr_pkg.sv
/*
 * Types shared by the resolver modules.
 * Assumes epr_defs.svh is available on the include path.
 */
package epr_pkg;
	typedef logic [7:0]  epr_byte_t;
	typedef logic [15:0] epr_vec_t;

	// One-hot register select produced by the address decoder.
	typedef enum logic [4:0] {
		SEL_NONE = 5'b00001,
		SEL_CCR  = 5'b00010,
		SEL_PRIO = 5'b00100,
		SEL_IRQC = 5'b01000,
		SEL_STAT = 5'b10000
	} epr_sel_t;
endpackage : epr_pkg

//--- rtl/epr_rank_if.sv
/*
 * Carrier between the resolver top and the maskable ranking module.
 * Assumes both ends run on the same clock; the ranking is combinational.
 */
`timescale 1ns/100ps
`include "epr_defs.svh"
interface epr_rank_if #(parameter int N_SRC = `EPR_N_MASK);
	logic [N_SRC-1:0]  pend;
	epr_pkg::epr_byte_t prio_sel;
	logic              win_valid;
	epr_pkg::epr_byte_t win_low;

	modport ranker (input pend, input prio_sel, output win_valid, output win_low);
	modport user   (output pend, output prio_sel, input win_valid, input win_low);
endinterface : epr_rank_if

//--- rtl/epr_sync.sv
/*
 * Two-flop synchroniser for pins that arrive from outside the clock domain.
 * Assumes each bit is an independent level; no bus coherency is kept.
 */
`timescale 1ns/100ps
module epr_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q, s1_d, s2_d;

	// Only the second stage reads the first, so a metastable sample settles.
	always_comb begin
		s1_d = d;
		s2_d = s1_q;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s1_q <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			s1_q <= s1_d;
			q    <= s2_d;
		end
	end
endmodule : epr_sync

//--- rtl/epr_rank.sv
/*
 * Maskable ranking: picks the winning pending source and its vector byte.
 * Assumes pend is already gated by the global mask and the local enables.
 */
`timescale 1ns/100ps
`include "epr_defs.svh"
module epr_rank #(
	parameter int N_SRC = `EPR_N_MASK
) (
	epr_rank_if.ranker rk
);
	import epr_pkg::*;

	localparam int IW = $clog2(N_SRC);

	// Fixed vector byte of each source index, default order first.
	function automatic epr_byte_t vec_low(input int idx);
		if (idx < `EPR_GRP1_LEN)
			vec_low = 8'(`EPR_VEC_IRQ - `EPR_VEC_STEP * idx);
		else if (idx < `EPR_GRP2_END)
			vec_low = 8'(`EPR_VEC_ATD - `EPR_VEC_STEP * (idx - `EPR_GRP1_LEN));
		else
			vec_low = 8'(`EPR_VEC_MDC - `EPR_VEC_STEP * (idx - `EPR_GRP2_END));
	endfunction : vec_low

	logic [IW-1:0] promo_idx;
	logic [IW-1:0] win_idx;
	logic          any;

	// A select value that matches no source leaves index 0, the pin request, on top.
	always_comb begin
		promo_idx = '0; // [R11]
		for (int i = 0; i < N_SRC; i++) begin
			if (rk.prio_sel == vec_low(i))
				promo_idx = IW'(i);
		end
	end

	// Promotion moves one source up; everyone else keeps the default order.
	always_comb begin
		any     = 1'b0;
		win_idx = '0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (rk.pend[i]) begin
				any     = 1'b1;
				win_idx = IW'(i); // [R7]
			end
		end
		if (rk.pend[promo_idx])
			win_idx = promo_idx; // [R7]
		rk.win_valid = any;
		rk.win_low   = vec_low(int'(win_idx)); // [R9]
	end
endmodule : epr_rank

//--- tb/epr_top_properties.sv
/* Concurrent checks on the resolver top ports.
 * Assumes bind into epr_top; the reset pin is quiet for three edges before a check. */
`timescale 1ns/100ps
module epr_top_properties #(
	parameter int N_MASK = 19
) (
	input wire logic              clk,
	input wire logic              reset,
	input wire logic              ext_reset_n,
	input wire logic              nonmaskable_pin_request_n,
	input wire logic              clock_monitor_fail,
	input wire logic              watchdog_reset,
	input wire logic              illegal_opcode_trap,
	input wire logic              software_trap_instruction,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire epr_pkg::epr_vec_t vector_addr,
	input wire logic              vector_valid,
	input wire logic              global_mask,
	input wire logic              pin_mask
);
	import epr_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised pins lag two edges, so a quiet pin must hold for three samples.
	sequence s_rst_quiet;
		ext_reset_n && $past(ext_reset_n) && $past(ext_reset_n, 2);
	endsequence
	sequence s_nmi_quiet;
		nonmaskable_pin_request_n && $past(nonmaskable_pin_request_n)
			&& $past(nonmaskable_pin_request_n, 2);
	endsequence

	property p_vec_page;
		vector_addr[15:8] == 8'hFF;
	endproperty
	a_vec_page: assert property (p_vec_page) else $error("vector outside top page");
	property p_reset_mask;
		$fell(reset) |-> global_mask && pin_mask && !vector_valid;
	endproperty
	a_reset_mask: assert property (p_reset_mask) else $error("mask bits not set at reset");
	property p_cm_first;
		clock_monitor_fail ##0 s_rst_quiet |=> vector_addr == 16'hFFFC && vector_valid;
	endproperty
	a_cm_first: assert property (p_cm_first) else $error("clock monitor not on top");
	property p_wd_next;
		watchdog_reset && !clock_monitor_fail ##0 s_rst_quiet |=> vector_addr == 16'hFFFA;
	endproperty
	a_wd_next: assert property (p_wd_next) else $error("watchdog rank wrong");
	property p_trap_next;
		illegal_opcode_trap && !clock_monitor_fail && !watchdog_reset ##0 s_rst_quiet
			|=> vector_addr == 16'hFFF8 && vector_valid;
	endproperty
	a_trap_next: assert property (p_trap_next) else $error("trap rank wrong");
	property p_swi_next;
		software_trap_instruction && !illegal_opcode_trap && !clock_monitor_fail
			&& !watchdog_reset ##0 s_rst_quiet |=> vector_addr == 16'hFFF6;
	endproperty
	a_swi_next: assert property (p_swi_next) else $error("software trap rank wrong");
	property p_pin_masked;
		pin_mask |=> vector_addr != 16'hFFF4;
	endproperty
	a_pin_masked: assert property (p_pin_masked) else $error("masked pin request served");
	property p_mask_gated;
		global_mask && !(clock_monitor_fail || watchdog_reset || illegal_opcode_trap
			|| software_trap_instruction) ##0 s_rst_quiet ##0 s_nmi_quiet
			|=> !vector_valid && vector_addr == 16'hFFF8;
	endproperty
	a_mask_gated: assert property (p_mask_gated) else $error("maskable seen while masked");
	property p_read_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_ans: assert property (p_read_ans) else $error("read answer late");
endmodule : epr_top_properties

bind epr_top epr_top_properties #(.N_MASK(N_MASK)) u_props (.clk, .reset, .ext_reset_n,
	.nonmaskable_pin_request_n, .clock_monitor_fail, .watchdog_reset, .illegal_opcode_trap,
	.software_trap_instruction, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.vector_addr, .vector_valid, .global_mask, .pin_mask);

//--- tb/epr_seq_model.sv
/* Exception sequencer model: takes the shown vector once while armed.
 * Assumes the resolver samples svc_take on the next rising edge. */
`timescale 1ns/100ps
module epr_seq_model (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              arm,
	input  wire logic              any,
	input  wire logic [1:0]        delay,
	input  wire logic              vector_valid,
	input  wire epr_pkg::epr_vec_t vector_addr,
	output logic                   svc_take,
	output epr_pkg::epr_vec_t      taken
);
	logic [1:0] cnt_q;
	logic       done_q;

	// A slow delay lets a request change before servicing, as a real core may.
	always_ff @(posedge clk) begin
		svc_take <= 1'b0;
		if (svc_take)
			taken <= vector_addr;
		if (reset || !arm) begin
			cnt_q <= 2'h0;
			done_q <= 1'b0;
		end else if (!done_q && (vector_valid || any)) begin
			if (cnt_q == delay) begin
				svc_take <= 1'b1;
				done_q <= 1'b1;
			end else
				cnt_q <= cnt_q + 2'h1;
		end
	end
endmodule : epr_seq_model

//--- tb/test_exception_priority_resolver.sv
/* Self-checking bench for the resolver: register bus, ranking and servicing.
 * Assumes the sequencer model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
module test_exception_priority_resolver;
	import epr_pkg::*;
	logic        clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, ext_reset_n, clock_monitor_fail;
	logic        watchdog_reset, illegal_opcode_trap, software_trap_instruction;
	logic        nonmaskable_pin_request_n, irq_pin_n, svc_take, vector_valid;
	logic        global_mask, pin_mask, arm, any;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp, delay;
	logic [17:0] periph_flag, periph_enable;
	epr_vec_t    vector_addr, taken;
	int          errors = 0;
	int          samples_checked = 0;

	epr_top #(.N_MASK(19)) dut_u (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ext_reset_n, .clock_monitor_fail, .watchdog_reset, .illegal_opcode_trap,
		.software_trap_instruction, .nonmaskable_pin_request_n, .irq_pin_n, .periph_flag,
		.periph_enable, .svc_take, .vector_addr, .vector_valid, .global_mask, .pin_mask);
	epr_seq_model seq_u (.clk, .reset, .arm, .any, .delay, .vector_valid, .vector_addr,
		.svc_take, .taken);

	// Free-running 200 MHz clock.
	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Both write channels are offered together and each is dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge clk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Waits for the model's service pulse under a bound, then lets its effects land.
	task automatic serve(input logic [1:0] dl, input logic anyv);
		delay <= dl;
		any <= anyv;
		arm <= 1'b1;
		for (int n = 0; n < 20 && !svc_take; n++) @(posedge clk);
		// A service pulse that never comes is a failure in its own right.
		if (!svc_take)
			errors++;
		tick(2);
		arm <= 1'b0;
		any <= 1'b0;
	endtask : serve

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(global_mask, 1'b1);
		rd(8'h00);
		chk(d[6:4], 3'h5);
		rd(8'h04);
		chk(d[7:0], 8'hF2);
		rd(8'h10);
		chk(resp, 2'b10);
		nonmaskable_pin_request_n <= 1'b0;
		tick(4);
		chk(vector_valid, 1'b0);
		nonmaskable_pin_request_n <= 1'b1;
		wr(8'h00, 32'h10);
		s_axi_wstrb <= 4'h0;
		wr(8'h00, 32'h00);
		chk(resp, 2'b00);
		chk(global_mask, 1'b1);
		s_axi_wstrb <= 4'hF;
		tick(4);
		chk(pin_mask, 1'b0);
	endtask : t_reset

	// The first pass raises all six non-maskable requests; each later pass drops the highest remaining one.
	task automatic t_order();
		for (int k = 0; k < 7; k++) begin
			ext_reset_n <= (k > 0);
			clock_monitor_fail <= (k <= 1);
			watchdog_reset <= (k <= 2);
			illegal_opcode_trap <= (k <= 3);
			software_trap_instruction <= (k <= 4);
			nonmaskable_pin_request_n <= (k > 5);
			tick(4);
			chk(vector_valid, k < 6);
			if (k < 6)
				chk(vector_addr, 16'hFFFE - 16'(k * 2));
		end
	endtask : t_order

	task automatic t_rank();
		periph_enable <= '1;
		periph_flag <= 18'h24001;
		tick(2);
		chk(vector_valid, 1'b0);
		wr(8'h00, 32'h00);
		tick(2);
		chk(vector_addr, 16'hFFF0);
		wr(8'h04, 32'hCA);
		chk(resp, 2'b10);
		tick(2);
		chk(vector_addr, 16'hFFF0);
		wr(8'h00, 32'h10);
		wr(8'h04, 32'hCA);
		chk(resp, 2'b00);
		wr(8'h00, 32'h00);
		tick(2);
		chk(vector_addr, 16'hFFCA);
		periph_enable <= 18'h1FFFF;
		tick(2);
		chk(vector_addr, 16'hFFF0);
		periph_flag <= 18'h04000;
		tick(2);
		chk(vector_addr, 16'hFFD2);
		wr(8'h00, 32'h10);
		tick(2);
		chk(vector_valid, 1'b0);
		wr(8'h04, 32'hD4);
		wr(8'h00, 32'h00);
		periph_enable <= '1;
		periph_flag <= 18'h24000;
		tick(2);
		chk(vector_addr, 16'hFFD2);
		periph_flag <= '0;
	endtask : t_rank

	task automatic t_service();
		wr(8'h08, 32'hC0);
		rd(8'h08);
		chk(d[7:0], 8'hC0);
		irq_pin_n <= 1'b0;
		tick(2);
		irq_pin_n <= 1'b1;
		tick(4);
		chk(vector_addr, 16'hFFF2);
		rd(8'h0C);
		chk(d, 32'hFFF2_0003);
		chk(resp, 2'b00);
		serve(2'd2, 1'b0);
		chk(taken, 16'hFFF2);
		wr(8'h00, 32'h00);
		tick(2);
		chk(vector_valid, 1'b0);
		wr(8'h08, 32'h40);
		irq_pin_n <= 1'b0;
		tick(4);
		chk(vector_addr, 16'hFFF2);
		irq_pin_n <= 1'b1;
		tick(4);
		serve(2'd0, 1'b1);
		chk(taken, 16'hFFF8);
	endtask : t_service

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////////////
	// Every input gets a level at time zero; pins idle high.
	initial begin
		{clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{clock_monitor_fail, watchdog_reset, illegal_opcode_trap, arm, any} = '0;
		{software_trap_instruction, periph_flag, periph_enable, delay} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{ext_reset_n, nonmaskable_pin_request_n, irq_pin_n, reset} = 4'hF;
		s_axi_wstrb = 4'hF;
		tick(20);
		reset <= 1'b0;
		t_reset();
		t_order();
		t_rank();
		t_service();
		summarize();
	end

	// The tests need well under a thousand cycles, so this span only trips on a hang.
	initial begin
		tick(20000);
		errors++;
		summarize();
	end
endmodule : test_exception_priority_resolver
